// ---- src/gpfg_defines.vh ----
`ifndef GPFG_DEFINES_VH
`define GPFG_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define GPFG_OFF_F_LATCH   12'h000
`define GPFG_OFF_F_DIR     12'h004
`define GPFG_OFF_G_LATCH   12'h008
`define GPFG_OFF_G_DIR     12'h00C
`define GPFG_OFF_G_PULLUP  12'h010
`define GPFG_OFF_CTRL      12'h014
`define GPFG_OFF_STATUS    12'h018

// ----------------------------------------
// Implemented bit masks and reset values
// ----------------------------------------
`define GPFG_F_MASK        8'h07
`define GPFG_G_MASK        8'h06
`define GPFG_RST_LATCH     8'h00
`define GPFG_RST_DIR       8'h00
`define GPFG_RST_PULLUP    8'h00

// ----------------------------------------
// Control and status register fields
// ----------------------------------------
`define GPFG_CTRL_FLOAT_BIT 0
`define GPFG_CTRL_RMW_BIT   1
`define GPFG_CTRL_STBY_BIT  2

`endif

// ---- src/gpfg_pin_cell.v ----
`timescale 1ns/1ps

// Per-pin output and input path, registered outputs
module gpfg_pin_cell #(
	parameter OPEN_DRAIN = 0,
	parameter HAS_PULLUP = 0
) (
	input  wire pclk,
	input  wire presetn,
	input  wire latch_bit,
	input  wire dir_bit,
	input  wire pullup_bit,
	input  wire float_pins,
	input  wire pin_in,
	output reg  pin_out,
	output reg  pin_oe,
	output reg  pin_pullup,
	output reg  pin_sampled
);

	// ----------------------------------------
	// Drive, enable and pull-up decode
	// ----------------------------------------
	wire drive_en;
	wire drives_low;

	// Open-drain pins only drive low; a 1 releases the pin
	assign drive_en   = dir_bit & ~float_pins & ((OPEN_DRAIN == 0) | ~latch_bit); // see (R1) (R2) (R8) (R11)
	assign drives_low = drive_en & ~latch_bit;

	// Registered pin outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out     <= 1'b0;
			pin_oe      <= 1'b0;
			pin_pullup  <= 1'b0;
			pin_sampled <= 1'b0;
		end else begin
			pin_out     <= latch_bit; // see (R3) (R10)
			pin_oe      <= drive_en;
			pin_pullup  <= (HAS_PULLUP != 0) & pullup_bit & ~drives_low
			               & ~float_pins; // see (R14) (R15)
			pin_sampled <= pin_in & ~float_pins; // see (R9)
		end
	end

endmodule // gpfg_pin_cell

// ---- src/gpfg_ports.v ----
// Functional notes
// (R1) Port F pin is output when direction bit is 1, input when 0.
// (R2) Port G pin is output when direction bit is 1, input when 0.
// (R3) An output pin drives its port's output latch value.
// (R4) Data writes always update the latch; pins see it only as outputs.
// (R5) Reading an output pin returns the latch, not the pin.
// (R6) Reading an input pin returns pin level; read-modify-write reads return the latch.
// (R7) Reset clears every direction bit so all pins start as inputs.
// (R8) Float bit set in stop or watch mode forces every pin to high impedance.
// (R9) A floated pin's input is blocked and held low.
// (R10) Float bit clear in standby leaves pins and driven levels unchanged.
// (R11) Open-drain port F pin writing 1 as output releases the pin.
// (R12) Port F implements bits 0 to 2 only, one pin each.
// (R13) Port G implements bits 1 and 2 only, one pin each.
// (R14) Port G pull-up bit 1 connects the pull-up; 0 disconnects it.
// (R15) Port G pull-up is disconnected while the pin drives low.
// (R16) Software disables shared peripheral outputs before using a pin as a port.
// (R17) Unimplemented register bits ignore writes and read as zero.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "gpfg_defines.vh"

module gpfg_ports #(
	parameter F_OPEN_DRAIN = 3'b100
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        standby_stop_watch,
	input  wire [2:0]  port_f_pin_in,
	output wire [2:0]  port_f_pin_out,
	output wire [2:0]  port_f_pin_oe,
	input  wire [2:0]  port_g_pin_in,
	output wire [2:0]  port_g_pin_out,
	output wire [2:0]  port_g_pin_oe,
	output wire [2:0]  port_g_pullup_on
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [7:0] port_f_output_latch_r;
	reg  [7:0] port_f_direction_r;
	reg  [7:0] port_g_output_latch_r;
	reg  [7:0] port_g_direction_r;
	reg  [7:0] port_g_pullup_enable_r;
	reg        standby_pin_float_bit_r;
	reg        rmw_read_r;
	wire [2:0] f_sampled;
	wire [2:0] g_sampled;
	wire       float_pins;
	wire       wr_en;
	wire       rd_ok;
	reg  [31:0] rd_data;
	reg         rd_hit;
	wire [7:0]  g_pin_mask;

	// Port G bit 0 has no pin; its input is tied off
	assign g_pin_mask = `GPFG_G_MASK; // see (R13)

	// Port data read: latch for outputs or read-modify-write, else pin
	function [7:0] port_read;
		input [7:0] latch;
		input [7:0] dir;
		input [7:0] pin;
		input [7:0] mask;
		input       rmw;
		begin
			port_read = (rmw ? latch : ((latch & dir) | (pin & ~dir))) & mask; // see (R5) (R6)
		end
	endfunction

	// Pins float only when the bit is set and standby is entered
	assign float_pins = standby_pin_float_bit_r & standby_stop_watch; // see (R8) (R10)
	assign wr_en      = psel & penable & pwrite & pstrb[0];
	assign rd_ok      = 1'b1;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Only implemented bits are stored
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_f_output_latch_r   <= `GPFG_RST_LATCH;
			port_f_direction_r      <= `GPFG_RST_DIR; // see (R7)
			port_g_output_latch_r   <= `GPFG_RST_LATCH;
			port_g_direction_r      <= `GPFG_RST_DIR; // see (R7)
			port_g_pullup_enable_r  <= `GPFG_RST_PULLUP;
			standby_pin_float_bit_r <= 1'b0;
			rmw_read_r              <= 1'b0;
		end else if (wr_en) begin
			case (paddr)
				`GPFG_OFF_F_LATCH:  port_f_output_latch_r  <= pwdata[7:0] & `GPFG_F_MASK; // see (R4) (R12) (R17)
				`GPFG_OFF_F_DIR:    port_f_direction_r     <= pwdata[7:0] & `GPFG_F_MASK; // see (R12) (R17)
				`GPFG_OFF_G_LATCH:  port_g_output_latch_r  <= pwdata[7:0] & `GPFG_G_MASK; // see (R4) (R13) (R17)
				`GPFG_OFF_G_DIR:    port_g_direction_r     <= pwdata[7:0] & `GPFG_G_MASK; // see (R13) (R17)
				`GPFG_OFF_G_PULLUP: port_g_pullup_enable_r <= pwdata[7:0] & `GPFG_G_MASK; // see (R13) (R17)
				`GPFG_OFF_CTRL: begin
					standby_pin_float_bit_r <= pwdata[`GPFG_CTRL_FLOAT_BIT];
					rmw_read_r              <= pwdata[`GPFG_CTRL_RMW_BIT];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	always @* begin
		rd_data = 32'h00000000;
		rd_hit  = 1'b1;
		case (paddr)
			`GPFG_OFF_F_LATCH:  rd_data[7:0] = port_read(port_f_output_latch_r, port_f_direction_r,
			                        {5'h00, f_sampled}, `GPFG_F_MASK, rmw_read_r);
			`GPFG_OFF_F_DIR:    rd_data[7:0] = port_f_direction_r;
			`GPFG_OFF_G_LATCH:  rd_data[7:0] = port_read(port_g_output_latch_r, port_g_direction_r,
			                        {5'h00, g_sampled}, `GPFG_G_MASK, rmw_read_r);
			`GPFG_OFF_G_DIR:    rd_data[7:0] = port_g_direction_r;
			`GPFG_OFF_G_PULLUP: rd_data[7:0] = port_g_pullup_enable_r;
			`GPFG_OFF_CTRL:     rd_data[1:0] = {rmw_read_r, standby_pin_float_bit_r};
			`GPFG_OFF_STATUS:   rd_data[`GPFG_CTRL_STBY_BIT:0] = {float_pins, 2'b00};
			default:            rd_hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// APB answer: no wait states, registered
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			if (psel & ~penable) begin
				pready  <= rd_ok;
				pslverr <= ~rd_hit;
				prdata  <= pwrite ? 32'h00000000 : rd_data;
			end
		end
	end

	// ----------------------------------------
	// Pin cells
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_f
			gpfg_pin_cell #(.OPEN_DRAIN(F_OPEN_DRAIN[i]), .HAS_PULLUP(0)) u_f (
				.pclk        (pclk),
				.presetn     (presetn),
				.latch_bit   (port_f_output_latch_r[i]),
				.dir_bit     (port_f_direction_r[i]), // see (R1)
				.pullup_bit  (1'b0),
				.float_pins  (float_pins),
				.pin_in      (port_f_pin_in[i]),
				.pin_out     (port_f_pin_out[i]),
				.pin_oe      (port_f_pin_oe[i]),
				.pin_pullup  (),
				.pin_sampled (f_sampled[i])
			);
			// Port G bit 0 has no pin; its cell sees zero latch, direction and pull-up bits
			gpfg_pin_cell #(.OPEN_DRAIN(0), .HAS_PULLUP(1)) u_g (
				.pclk        (pclk),
				.presetn     (presetn),
				.latch_bit   (port_g_output_latch_r[i]),
				.dir_bit     (port_g_direction_r[i]), // see (R2)
				.pullup_bit  (port_g_pullup_enable_r[i]), // see (R14)
				.float_pins  (float_pins),
				.pin_in      (port_g_pin_in[i] & g_pin_mask[i]),
				.pin_out     (port_g_pin_out[i]),
				.pin_oe      (port_g_pin_oe[i]),
				.pin_pullup  (port_g_pullup_on[i]),
				.pin_sampled (g_sampled[i])
			);
		end
	endgenerate

endmodule // gpfg_ports

// ---- verification/gpfg_pins_model.sv ----
`timescale 1ns/1ps
module gpfg_pins_model (
	input wire        pclk,
	input wire  [5:0] pout, poe, ppu, xen, xval,
	output wire [5:0] pin
);
	reg [5:0] last_r = 6'h00;
	// Device first, outside driver second, then pull-up, else wander
	assign pin = poe & pout | ~poe & (xen & xval | ~xen & (ppu | ~last_r));
	always @(posedge pclk) last_r <= pin;
endmodule // gpfg_pins_model

// ---- verification/gpfg_ports_properties.sv ----
`timescale 1ns/1ps
// ----------
// Port checks
// ----------
module gpfg_ports_properties #(parameter F_OPEN_DRAIN = 3'h4) (
	input wire        pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire [31:0] prdata,
	input wire [2:0]  port_f_pin_out, port_f_pin_oe, port_g_pin_out, port_g_pin_oe,
	input wire [2:0]  port_g_pullup_on
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ans; psel && !penable |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("no ready");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready held");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_top; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
	a_top: assert property (p_top) else $error("upper bits");
	property p_g0; !port_g_pin_oe[0] && !port_g_pullup_on[0]; endproperty
	a_g0: assert property (p_g0) else $error("g0 active");
	property p_pul; !(port_g_pullup_on & port_g_pin_oe & ~port_g_pin_out); endproperty
	a_pul: assert property (p_pul) else $error("pull-up low");
	property p_od; !(port_f_pin_oe & F_OPEN_DRAIN & port_f_pin_out); endproperty
	a_od: assert property (p_od) else $error("drain high");
	property p_rst; $rose(presetn) |-> !{port_f_pin_oe, port_g_pin_oe}; endproperty
	a_rst: assert property (p_rst) else $error("oe at reset");
endmodule // gpfg_ports_properties
bind gpfg_ports gpfg_ports_properties #(.F_OPEN_DRAIN(F_OPEN_DRAIN))
	i_gpfg_ports_properties (.*);

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
	bit          pclk, presetn, psel, penable, pwrite, standby_stop_watch;
	bit   [11:0] paddr;
	bit   [31:0] pwdata;
	bit   [5:0]  xen, xval;
	logic [31:0] prdata;
	logic        pready, pslverr;
	logic [2:0]  port_f_pin_out, port_f_pin_oe, port_g_pin_out, port_g_pin_oe, port_g_pullup_on;
	logic [5:0]  pins;
	int          mismatches, n_compared;
	always #4 pclk = ~pclk;
	gpfg_ports i_gpfg_ports (.*, .pstrb(4'hF), .port_f_pin_in(pins[2:0]),
		.port_g_pin_in(pins[5:3]));
	gpfg_pins_model i_gpfg_pins_model (.pclk, .pout({port_g_pin_out, port_f_pin_out}),
		.poe({port_g_pin_oe, port_f_pin_oe}), .ppu({port_g_pullup_on, 3'h0}), .xen, .xval,
		.pin(pins));
	task automatic chk(input string n, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// One APB transfer, held until ready
	task automatic apb(input bit w, input bit [11:0] a, input bit [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input string n, input bit [11:0] a, input bit [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(n, {24'h0, e}, prdata);
	endtask
	task t_out;
		rd("dir f", 12'h004, 8'h00);
		apb(1'b1, 12'h000, 8'hFD);
		apb(1'b1, 12'h004, 8'hFF);
		repeat (3) @(posedge pclk);
		chk("oe f", 5'h0D, {port_f_pin_oe, pins[1:0]});
		rd("latch f", 12'h000, 8'h05);
		apb(1'b0, 12'h020, 8'h00);
		chk("slverr", 1'b1, pslverr);
	endtask
	task t_in;
		apb(1'b1, 12'h004, 8'h00);
		xen <= 6'h3F;
		xval <= 6'h1A;
		repeat (3) @(posedge pclk);
		rd("pin f", 12'h000, 8'h02);
		rd("pin g", 12'h008, 8'h02);
		apb(1'b1, 12'h014, 8'h02);
		rd("rmw f", 12'h000, 8'h05);
	endtask
	task t_pull;
		apb(1'b1, 12'h008, 8'h02);
		apb(1'b1, 12'h010, 8'hFF);
		apb(1'b1, 12'h00C, 8'hFF);
		repeat (3) @(posedge pclk);
		chk("oe pu g", 6'h32, {port_g_pin_oe, port_g_pullup_on});
		rd("pu g", 12'h010, 8'h06);
	endtask
	task t_float;
		standby_stop_watch <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("hold g", 5'h19, {port_g_pin_oe, pins[5:4]});
		apb(1'b1, 12'h014, 8'h01);
		repeat (3) @(posedge pclk);
		chk("float", 9'h000, {port_g_pin_oe, port_g_pullup_on, port_f_pin_oe});
		rd("float in", 12'h000, 8'h00);
		rd("float status", 12'h018, 8'h04);
		standby_stop_watch <= 1'b0;
	endtask
	task conclude;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_out;
		t_in;
		t_pull;
		t_float;
		conclude;
	end
	initial begin
		repeat (2000) @(posedge pclk);
		mismatches++;
		conclude;
	end
endmodule // tb
